// *** design/ckc_pkg.sv ***
// ckc_pkg: register map, field positions, reset values, types
// assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register
package ckc_pkg;

  // register indices and byte addresses (address = index * 4)
  localparam logic [7:0] CLOCK_CONTROL_IDX = 8'h8f;
  localparam logic [7:0] PLL_CONTROL_IDX = 8'he9;
  localparam logic [7:0] REF_DIVIDER_IDX = 8'hee;
  localparam logic [7:0] FB_DIVIDER_HIGH_IDX = 8'hef;
  localparam logic [11:0] CLOCK_CONTROL_ADDR = {2'h0, CLOCK_CONTROL_IDX, 2'h0};
  localparam logic [11:0] PLL_CONTROL_ADDR = {2'h0, PLL_CONTROL_IDX, 2'h0};
  localparam logic [11:0] REF_DIVIDER_ADDR = {2'h0, REF_DIVIDER_IDX, 2'h0};
  localparam logic [11:0] FB_DIVIDER_HIGH_ADDR =
    {2'h0, FB_DIVIDER_HIGH_IDX, 2'h0};

  // clock_control fields
  localparam int DOUBLE_SPEED_POS = 0;
  localparam int TIMER0_SEL_POS = 1;
  localparam int TIMER1_SEL_POS = 2;
  localparam int SERIAL_SEL_POS = 4;
  localparam int WATCHDOG_SEL_POS = 6;
  localparam int TWO_WIRE_SEL_POS = 7;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;

  // pll_control fields
  localparam int PLL_LOCK_POS = 0;
  localparam int PLL_ENABLE_POS = 1;
  localparam int PLL_RESET_POS = 3;
  localparam int FB_LOW_LSB_POS = 6;
  localparam logic [7:0] PLL_CONTROL_RESET = 8'h08;
  localparam logic [6:0] REF_DIVIDER_RESET = 7'h00;
  localparam logic [9:0] FB_DIVIDER_RESET = 10'h000;

  // timing counts
  localparam logic [2:0] MACHINE_CPU_CLOCKS = 3'h6;
  localparam int LOCK_PERIODS = 8;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PLL_HELD = 4'b0001,
    PLL_IDLE = 4'b0010,
    PLL_ACQUIRE = 4'b0100,
    PLL_LOCKED = 4'b1000
  } ckc_pll_state_t;

  // one-cycle clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu;
    logic periph;
    logic timer0;
    logic timer1;
    logic mem_card;
    logic adc;
    logic spi;
    logic port_sample;
    logic two_wire;
    logic watchdog;
    logic serial;
    logic pll_ref;
    logic pll_out;
    logic machine_cycle;
  } ckc_clk_en_t;

  // phase-frequency detector outputs
  typedef struct packed {
    logic up;
    logic down;
  } ckc_pfd_t;

endpackage

// *** design/ckc_clock_controller.sv ***
// ckc_clock_controller: oscillator-derived clock enables, speed select,
// per-peripheral source select, and the digital side of the pll
// assumes clk_i is the oscillator clock; the vco output arrives as a pin
// Functional notes
// RULE1: cpu, peripheral, pll reference gated by power mode
// RULE2: peripheral enable feeds timers, card, adc, spi, ports
// RULE3: speed select moves cpu and peripheral together
// RULE4: standard is osc/2, double speed is osc
// RULE5: reset starts in standard clocking
// RULE6: flash variant resets speed from fuse
// RULE7: bit 0 sets 12 or 6 periods per cycle
// RULE8: bit 7 puts two-wire on osc/2
// RULE9: bit 6 puts watchdog on osc/2
// RULE10: bit 4 puts serial modes 0/2 on osc/2
// RULE11: bit 2 puts timer 1 on osc/2
// RULE12: bit 1 puts timer 0 on osc/2
// RULE13: bits 5 and 3 reserved, never set
// RULE14: pll output feeds decoder, audio, usb
// RULE15: detector compares divided reference and feedback
// RULE16: pll enable bit starts pll clocking
// RULE17: lock flag follows lock, hardware cleared
// RULE18: software waits for lock before use
// RULE19: pll reset bit holds pll, set at reset
// RULE20: 7-bit reference, 10-bit feedback divider split
// RULE21: pll output silent while reset or disabled
// RULE22: speed change only on divider boundary
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module ckc_clock_controller #(
  parameter bit FLASH_VARIANT = 1'b1,
  parameter int LOCK_PERIODS = ckc_pkg::LOCK_PERIODS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // fuse and power mode
  input wire logic boot_speed_fuse_i,
  input wire logic idle_i,
  input wire logic power_down_i,
  // vco output pin
  input wire logic vco_clk_i,
  // clock enables and detector
  output ckc_pkg::ckc_clk_en_t clk_en_o,
  output ckc_pkg::ckc_pfd_t pfd_o
);

  initial begin
    if (LOCK_PERIODS < 1 || LOCK_PERIODS > 255) begin
      $error("LOCK_PERIODS must be 1..255");
    end
  end

  localparam logic [7:0] LOCK_LAST = 8'(LOCK_PERIODS - 1);

  // divider step: wraps at the limit when ticked
  function automatic logic [9:0] div_next(input logic [9:0] cnt,
                                          input logic [9:0] lim,
                                          input logic tick);
    div_next = cnt;
    if (tick) begin
      div_next = (cnt == lim) ? 10'h000 : 10'(cnt + 10'h001);
    end
  endfunction

  // registers
  logic [7:0] clock_control;
  logic pll_enable_bit;
  logic pll_reset_bit;
  logic [6:0] reference_divider;
  logic [9:0] feedback_divider;

  // ---------------- axi4-lite slave ----------------
  logic aw_full;
  logic w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_clock_control;
  logic wr_pll_control;
  logic wr_ref_div;
  logic wr_fb_high;
  logic wr_mapped;
  logic wr_low;
  logic rd_take;
  logic [7:0] rd_byte;
  logic rd_mapped;
  logic [7:0] pll_control_view;
  ckc_pkg::ckc_pll_state_t pll_state;

  assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_full && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_write = aw_full && w_full && !s_axi_bvalid_o;
  assign wr_low = do_write && w_strb[0];
  assign wr_clock_control = wr_low &&
    (aw_addr == ckc_pkg::CLOCK_CONTROL_ADDR);
  assign wr_pll_control = wr_low && (aw_addr == ckc_pkg::PLL_CONTROL_ADDR);
  assign wr_ref_div = wr_low && (aw_addr == ckc_pkg::REF_DIVIDER_ADDR);
  assign wr_fb_high = wr_low && (aw_addr == ckc_pkg::FB_DIVIDER_HIGH_ADDR);
  assign wr_mapped = (aw_addr == ckc_pkg::CLOCK_CONTROL_ADDR) ||
    (aw_addr == ckc_pkg::PLL_CONTROL_ADDR) ||
    (aw_addr == ckc_pkg::REF_DIVIDER_ADDR) ||
    (aw_addr == ckc_pkg::FB_DIVIDER_HIGH_ADDR);
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

  // lock flag is the locked state itself
  assign pll_control_view = {feedback_divider[1:0], 2'h0, pll_reset_bit,
    1'b0, pll_enable_bit, pll_state == ckc_pkg::PLL_LOCKED};

  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    if (s_axi_araddr_i == ckc_pkg::CLOCK_CONTROL_ADDR) begin
      // RULE13 reserved bits read 0
      rd_byte = clock_control & 8'hd7;
    end else if (s_axi_araddr_i == ckc_pkg::PLL_CONTROL_ADDR) begin
      rd_byte = pll_control_view;
    end else if (s_axi_araddr_i == ckc_pkg::REF_DIVIDER_ADDR) begin
      rd_byte = {1'b0, reference_divider};
    end else if (s_axi_araddr_i == ckc_pkg::FB_DIVIDER_HIGH_ADDR) begin
      rd_byte = feedback_divider[9:2];
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_full <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= ckc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_mapped ? ckc_pkg::RESP_OKAY : ckc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= ckc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= rd_mapped ? ckc_pkg::RESP_OKAY : ckc_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------- register file ----------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // RULE5 standard after reset
      clock_control <= ckc_pkg::CLOCK_CONTROL_RESET;
      // RULE6 fuse sets speed on flash
      clock_control[ckc_pkg::DOUBLE_SPEED_POS] <=
        FLASH_VARIANT & boot_speed_fuse_i;
    end else if (wr_clock_control) begin
      // RULE13 reserved bits never stored
      clock_control <= w_data[7:0] & 8'hd7;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // RULE19 pll reset bit set
      pll_reset_bit <= ckc_pkg::PLL_CONTROL_RESET[ckc_pkg::PLL_RESET_POS];
      pll_enable_bit <= ckc_pkg::PLL_CONTROL_RESET[ckc_pkg::PLL_ENABLE_POS];
      reference_divider <= ckc_pkg::REF_DIVIDER_RESET;
      feedback_divider <= ckc_pkg::FB_DIVIDER_RESET;
    end else begin
      if (wr_pll_control) begin
        pll_reset_bit <= w_data[ckc_pkg::PLL_RESET_POS];
        pll_enable_bit <= w_data[ckc_pkg::PLL_ENABLE_POS];
        // RULE20 two low feedback bits
        feedback_divider[1:0] <=
          w_data[ckc_pkg::FB_LOW_LSB_POS +: 2];
      end
      if (wr_ref_div) begin
        // RULE20 seven-bit reference divider
        reference_divider <= w_data[6:0];
      end
      if (wr_fb_high) begin
        feedback_divider[9:2] <= w_data[7:0];
      end
    end
  end

  // ---------------- cpu / peripheral enables ----------------
  logic half_en;
  logic speed_active;
  logic [2:0] mc_cnt;
  logic cpu_raw;
  logic per_raw;
  logic per_gate;
  ckc_pkg::ckc_clk_en_t next_clk_en;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      half_en <= 1'b0;
      speed_active <= 1'b0;
    end else begin
      half_en <= !half_en;
      // RULE22 switch on divider boundary
      if (half_en) begin
        speed_active <= clock_control[ckc_pkg::DOUBLE_SPEED_POS];
      end
    end
  end

  // RULE3 one select for both
  // RULE4 osc or osc/2
  assign cpu_raw = speed_active ? 1'b1 : half_en;
  assign per_raw = cpu_raw;
  assign per_gate = per_raw && !power_down_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mc_cnt <= 3'h0;
    end else if (next_clk_en.cpu) begin
      mc_cnt <= (mc_cnt == ckc_pkg::MACHINE_CPU_CLOCKS - 3'h1) ?
        3'h0 : 3'(mc_cnt + 3'h1);
    end
  end

  // ---------------- pll digital part ----------------
  logic vco_s1;
  logic vco_s2;
  logic vco_s3;
  logic vco_level;
  logic vco_rise;
  logic pll_run;
  logic ref_tick;
  logic fb_tick;
  logic [9:0] ref_cnt;
  logic [9:0] fb_cnt;
  logic [1:0] fb_seen;
  logic period_ok;
  logic [7:0] lock_cnt;
  logic up_pend;
  logic down_pend;
  ckc_pkg::ckc_pll_state_t next_pll_state;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vco_s1 <= 1'b0;
      vco_s2 <= 1'b0;
      vco_s3 <= 1'b0;
      vco_level <= 1'b0;
    end else begin
      vco_s1 <= vco_clk_i;
      vco_s2 <= vco_s1;
      vco_s3 <= vco_s2;
      if (vco_s2 == vco_s3) begin
        vco_level <= vco_s3;
      end
    end
  end

  assign vco_rise = (vco_s2 == vco_s3) && vco_s3 && !vco_level;
  // RULE16 enable bit runs the pll
  assign pll_run = (pll_state == ckc_pkg::PLL_ACQUIRE) ||
    (pll_state == ckc_pkg::PLL_LOCKED);
  // RULE1 reference gated in power-down
  assign ref_tick = pll_run && !power_down_i &&
    (ref_cnt == {3'h0, reference_divider});
  assign fb_tick = pll_run && vco_rise && (fb_cnt == feedback_divider);
  assign period_ok = (fb_seen == 2'h1) && !fb_tick ||
    (fb_seen == 2'h0) && fb_tick;

  always_ff @(posedge clk_i) begin
    if (reset_i || !pll_run) begin
      ref_cnt <= 10'h000;
      fb_cnt <= 10'h000;
      fb_seen <= 2'h0;
    end else begin
      // RULE20 reference and feedback dividers
      ref_cnt <= div_next(ref_cnt, {3'h0, reference_divider}, !power_down_i);
      fb_cnt <= div_next(fb_cnt, feedback_divider, vco_rise);
      if (ref_tick) begin
        fb_seen <= 2'h0;
      end else if (fb_tick && fb_seen != 2'h2) begin
        fb_seen <= 2'(fb_seen + 2'h1);
      end
    end
  end

  // RULE15 edge order decides up or down
  always_ff @(posedge clk_i) begin
    if (reset_i || !pll_run) begin
      up_pend <= 1'b0;
      down_pend <= 1'b0;
    end else begin
      up_pend <= (up_pend || ref_tick) && !(down_pend || fb_tick);
      down_pend <= (down_pend || fb_tick) && !(up_pend || ref_tick);
    end
  end

  always_comb begin
    next_pll_state = pll_state;
    case (pll_state)
      ckc_pkg::PLL_HELD: begin
        if (!pll_reset_bit) begin
          next_pll_state = ckc_pkg::PLL_IDLE;
        end
      end
      ckc_pkg::PLL_IDLE: begin
        if (pll_reset_bit) begin
          next_pll_state = ckc_pkg::PLL_HELD;
        end else if (pll_enable_bit) begin
          next_pll_state = ckc_pkg::PLL_ACQUIRE;
        end
      end
      ckc_pkg::PLL_ACQUIRE: begin
        if (pll_reset_bit) begin
          next_pll_state = ckc_pkg::PLL_HELD;
        end else if (!pll_enable_bit) begin
          next_pll_state = ckc_pkg::PLL_IDLE;
        end else if (ref_tick && period_ok && lock_cnt == LOCK_LAST) begin
          next_pll_state = ckc_pkg::PLL_LOCKED;
        end
      end
      ckc_pkg::PLL_LOCKED: begin
        // RULE17 lock lost clears flag
        if (pll_reset_bit) begin
          next_pll_state = ckc_pkg::PLL_HELD;
        end else if (!pll_enable_bit) begin
          next_pll_state = ckc_pkg::PLL_IDLE;
        end else if (ref_tick && !period_ok) begin
          next_pll_state = ckc_pkg::PLL_ACQUIRE;
        end
      end
      default: next_pll_state = ckc_pkg::PLL_HELD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pll_state <= ckc_pkg::PLL_HELD;
      lock_cnt <= 8'h00;
    end else begin
      pll_state <= next_pll_state;
      // RULE17 count good periods to lock
      if (pll_state != ckc_pkg::PLL_ACQUIRE || (ref_tick && !period_ok)) begin
        lock_cnt <= 8'h00;
      end else if (ref_tick && lock_cnt != LOCK_LAST) begin
        lock_cnt <= 8'(lock_cnt + 8'h01);
      end
    end
  end

  // ---------------- enable outputs ----------------
  always_comb begin
    // RULE1 cpu stops in idle and power-down
    next_clk_en.cpu = cpu_raw && !idle_i && !power_down_i;
    next_clk_en.periph = per_gate;
    // RULE2 peripheral enable derived
    next_clk_en.mem_card = per_gate;
    next_clk_en.adc = per_gate;
    next_clk_en.spi = per_gate;
    next_clk_en.port_sample = per_gate;
    // RULE12 timer 0 source
    next_clk_en.timer0 = clock_control[ckc_pkg::TIMER0_SEL_POS] ?
      half_en && !power_down_i : per_gate;
    // RULE11 timer 1 source
    next_clk_en.timer1 = clock_control[ckc_pkg::TIMER1_SEL_POS] ?
      half_en && !power_down_i : per_gate;
    // RULE10 serial source
    next_clk_en.serial = clock_control[ckc_pkg::SERIAL_SEL_POS] ?
      half_en && !power_down_i : per_gate;
    // RULE9 watchdog source
    next_clk_en.watchdog = clock_control[ckc_pkg::WATCHDOG_SEL_POS] ?
      half_en && !power_down_i : per_gate;
    // RULE8 two-wire source
    next_clk_en.two_wire = clock_control[ckc_pkg::TWO_WIRE_SEL_POS] ?
      half_en && !power_down_i : per_gate;
    next_clk_en.pll_ref = ref_tick;
    // RULE14 vco ticks to decoder, audio, usb
    // RULE21 silent unless running
    next_clk_en.pll_out = pll_run && vco_rise;
    // RULE7 six cpu clocks per cycle
    next_clk_en.machine_cycle = next_clk_en.cpu &&
      (mc_cnt == ckc_pkg::MACHINE_CPU_CLOCKS - 3'h1);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clk_en_o <= '0;
      pfd_o <= '0;
    end else begin
      clk_en_o <= next_clk_en;
      pfd_o.up <= up_pend;
      pfd_o.down <= down_pend;
    end
  end

endmodule // ckc_clock_controller

// *** test/ckc_clock_controller_properties.sv ***
// ckc_clock_controller_properties: port-level checks of the controller
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/10ps
module ckc_clock_controller_properties #(
  parameter bit FLASH_VARIANT = 1'b1,
  parameter int LOCK_PERIODS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bus handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // power mode
  input wire logic idle_i,
  input wire logic power_down_i,
  // clock enables
  input ckc_pkg::ckc_clk_en_t clk_en_o
);
  logic [2:0] cpu_cnt;
  logic mc_valid;

  // cpu pulses since the last machine cycle
  always_ff @(posedge clk_i) begin
    if (reset_i || clk_en_o.machine_cycle) cpu_cnt <= 3'h0;
    else if (clk_en_o.cpu) cpu_cnt <= cpu_cnt + 3'h1;
  end

  // count trusted only after a clean machine cycle
  always_ff @(posedge clk_i) begin
    if (reset_i || idle_i || power_down_i) mc_valid <= 1'b0;
    else if (clk_en_o.machine_cycle) mc_valid <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_write_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  chk_cpu_in_periph: assert property (
    clk_en_o.cpu |-> clk_en_o.periph)
    else $error("cpu pulse without periph pulse");
  chk_periph_fanout: assert property (
    {clk_en_o.mem_card, clk_en_o.adc, clk_en_o.spi, clk_en_o.port_sample}
    == {4{clk_en_o.periph}})
    else $error("derived enable differs from periph");
  chk_power_gate: assert property (
    power_down_i [*3] |-> !(clk_en_o.cpu || clk_en_o.periph ||
    clk_en_o.pll_ref))
    else $error("enable pulse during power down");
  chk_idle_gate: assert property (
    idle_i [*3] |-> !clk_en_o.cpu && !clk_en_o.machine_cycle)
    else $error("cpu pulse during idle");
  chk_half_source: assert property (
    (clk_en_o.timer0 || clk_en_o.timer1 || clk_en_o.two_wire ||
    clk_en_o.watchdog || clk_en_o.serial) |-> clk_en_o.periph)
    else $error("selected source off the periph grid");
  chk_mc_six_cpu: assert property (
    clk_en_o.machine_cycle && mc_valid |-> clk_en_o.cpu && cpu_cnt == 3'h5)
    else $error("machine cycle not every sixth cpu pulse");
  chk_write_answer: assert property (
    s_write_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  chk_read_answer: assert property (s_read_taken |=> s_axi_rvalid_o)
    else $error("read data missing");
  chk_bresp_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
    $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
    $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  chk_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
endmodule // ckc_clock_controller_properties

bind ckc_clock_controller ckc_clock_controller_properties #(
  .FLASH_VARIANT(FLASH_VARIANT),
  .LOCK_PERIODS(LOCK_PERIODS)
) u_props (
  .clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .idle_i, .power_down_i, .clk_en_o
);

// *** test/ckc_vco_model.sv ***
// ckc_vco_model: free-running vco behind the loop filter pin
// assumes the bench picks a fast or a slow rate through slow_i
`timescale 1ns/10ps
module ckc_vco_model (
  // rate choice
  input wire logic slow_i,
  // vco output pin
  output logic vco_clk_o
);
  // edges kept off the oscillator grid
  initial begin
    vco_clk_o = 1'b0;
    #5;
    forever begin
      // two clock periods per level at least, so the pin synchroniser sees it
      if (slow_i) #80;
      else #40;
      vco_clk_o = ~vco_clk_o;
    end
  end
endmodule // ckc_vco_model

// *** test/ckc_clock_controller_tb.sv ***
// ckc_clock_controller_tb: speed table, bus map, pll and power tests
// assumes the vco model on the pin and the bound port checker
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ckc_clock_controller_tb;
  typedef struct packed {
    logic [7:0] cfg, cpu, per, t0, t1, tw, wd, si, mc;
  } ckc_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic fuse = 1'b1, idle = 1'b0, pdown = 1'b0, slow = 1'b0, vco;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  ckc_pkg::ckc_clk_en_t en;
  ckc_pkg::ckc_pfd_t pfd;
  int n_mismatch = 0, tests_run = 0, i;
  logic [7:0] cnt [16];
  ckc_row_t rows [9] = '{
    72'h00_0c0c_0c0c_0c0c_0c02, 72'h01_1818_1818_1818_1804,
    72'hd6_0c0c_0c0c_0c0c_0c02, 72'hd7_1818_0c0c_0c0c_0c04,
    72'h03_1818_0c18_1818_1804, 72'h05_1818_180c_1818_1804,
    72'h11_1818_1818_1818_0c04, 72'h41_1818_1818_180c_1804,
    72'h81_1818_1818_0c18_1804};

  ckc_clock_controller #(.FLASH_VARIANT(1'b1), .LOCK_PERIODS(2)) uut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .boot_speed_fuse_i(fuse), .idle_i(idle),
    .power_down_i(pdown), .vco_clk_i(vco), .clk_en_o(en), .pfd_o(pfd));
  ckc_vco_model u_vco (.slow_i(slow), .vco_clk_o(vco));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                           output logic [1:0] r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // pulses of each enable, detector levels in 14/15, over n cycles
  task automatic count_en(input int n = 24);
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 16; k++) cnt[k] = 8'h00;
    repeat (n) begin
      @(negedge clk_i);
      for (int k = 0; k < 14; k++) cnt[k] = cnt[k] + 8'(en[k]);
      cnt[14] = cnt[14] + 8'(pfd.up);
      cnt[15] = cnt[15] + 8'(pfd.down);
    end
  endtask

  task automatic read_chk(input logic [11:0] a);
    axi_read(a, rd, resp);
    `CHK(resp, ckc_pkg::RESP_OKAY)
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    read_chk(ckc_pkg::CLOCK_CONTROL_ADDR);
    `CHK(rd, 32'h0000_0001)
    count_en();
    `CHK(cnt[13], 8'h18)
    read_chk(ckc_pkg::PLL_CONTROL_ADDR);
    `CHK(rd, 32'h0000_0008)
    read_chk(ckc_pkg::REF_DIVIDER_ADDR);
    `CHK(rd, 32'h0000_0000)
    read_chk(ckc_pkg::FB_DIVIDER_HIGH_ADDR);
    `CHK(rd, 32'h0000_0000)
    $display("test reset values done");
    foreach (rows[k]) begin
      axi_write(ckc_pkg::CLOCK_CONTROL_ADDR, rows[k].cfg, resp);
      repeat (16) @(posedge clk_i);
      count_en();
      `CHK(cnt[13], rows[k].cpu)
      `CHK(cnt[12], rows[k].per)
      `CHK(cnt[11], rows[k].t0)
      `CHK(cnt[10], rows[k].t1)
      `CHK(cnt[5], rows[k].tw)
      `CHK(cnt[4], rows[k].wd)
      `CHK(cnt[3], rows[k].si)
      `CHK(cnt[0], rows[k].mc)
      read_chk(ckc_pkg::CLOCK_CONTROL_ADDR);
      `CHK(rd, {24'h00_0000, rows[k].cfg})
      $display("test speed row %0d done", k);
    end
    axi_write(12'h004, 8'hff, resp);
    `CHK(resp, ckc_pkg::RESP_SLVERR)
    axi_read(12'h004, rd, resp);
    `CHK(resp, ckc_pkg::RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
    read_chk(ckc_pkg::CLOCK_CONTROL_ADDR);
    `CHK(rd, 32'h0000_0081)
    $display("test unmapped done");
    count_en();
    `CHK(cnt[1], 8'h00)
    axi_write(ckc_pkg::REF_DIVIDER_ADDR, 8'h17, resp);
    axi_write(ckc_pkg::FB_DIVIDER_HIGH_ADDR, 8'h01, resp);
    axi_write(ckc_pkg::PLL_CONTROL_ADDR, 8'h40, resp);
    count_en();
    `CHK(cnt[1], 8'h00)
    axi_write(ckc_pkg::PLL_CONTROL_ADDR, 8'h42, resp);
    rd = 32'h0000_0000;
    for (i = 0; i < 100 && rd[0] !== 1'b1; i++) axi_read(
      ckc_pkg::PLL_CONTROL_ADDR, rd, resp);
    `CHK(rd, 32'h0000_0043)
    count_en();
    `CHK(cnt[1], 8'h06)
    `CHK(cnt[2], 8'h01)
    @(posedge clk_i);
    slow <= 1'b1;
    for (i = 0; i < 100 && rd[0] !== 1'b0; i++) axi_read(
      ckc_pkg::PLL_CONTROL_ADDR, rd, resp);
    `CHK(rd, 32'h0000_0042)
    count_en(48);
    `CHK(cnt[15], 8'h00)
    `CHK(cnt[14] != 8'h00, 1'b1)
    axi_write(ckc_pkg::PLL_CONTROL_ADDR, 8'h40, resp);
    count_en();
    `CHK(cnt[1], 8'h00)
    `CHK(cnt[14] | cnt[15], 8'h00)
    $display("test pll done");
    @(posedge clk_i);
    idle <= 1'b1;
    repeat (4) @(posedge clk_i);
    count_en();
    `CHK(cnt[13], 8'h00)
    `CHK(cnt[12], 8'h18)
    @(posedge clk_i);
    idle <= 1'b0;
    pdown <= 1'b1;
    repeat (4) @(posedge clk_i);
    count_en();
    `CHK(cnt[12], 8'h00)
    `CHK(cnt[2], 8'h00)
    @(posedge clk_i);
    pdown <= 1'b0;
    $display("test power modes done");
    @(posedge clk_i);
    fuse <= 1'b0;
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    read_chk(ckc_pkg::CLOCK_CONTROL_ADDR);
    `CHK(rd, 32'h0000_0000)
    count_en();
    `CHK(cnt[13], 8'h0c)
    $display("test second reset done");
    give_verdict();
  end
endmodule // ckc_clock_controller_tb
